// ===== design/fms_defs.vh
// constants for the flash array map and parameter-space reader
`ifndef FMS_DEFS_VH
`define FMS_DEFS_VH

// command codes taken from the serial input line
`define FMS_CMD_NONE 8'h00
`define FMS_CMD_READ 8'h03
`define FMS_CMD_PROG 8'h02
`define FMS_CMD_SECT_ERASE 8'h20
`define FMS_CMD_BLOCK_ERASE 8'hd8
`define FMS_CMD_CHIP_ERASE 8'hc7
`define FMS_CMD_RD_STATUS1 8'h05
`define FMS_CMD_RD_STATUS2 8'h35
`define FMS_CMD_WR_STATUS2 8'h31
`define FMS_CMD_SEC_READ 8'h48
`define FMS_CMD_SEC_PROG 8'h42
`define FMS_CMD_SEC_ERASE 8'h44
`define FMS_CMD_PARAM_READ 8'h5a

// array geometry
`define FMS_ARRAY_TOP 21'h1fffff
`define FMS_SEC_TOP 10'h3ff
`define FMS_SECTOR_BYTES 22'h001000
`define FMS_BLOCK_BYTES 22'h010000
`define FMS_CHIP_BYTES 22'h200000
`define FMS_REGION_BYTES 22'h000100
`define FMS_ARRAY_FIELD 20:0
`define FMS_BLOCK_FIELD 20:16
`define FMS_SECTOR_FIELD 20:12
`define FMS_PAGE_FIELD 20:8
`define FMS_OFFS_FIELD 7:0
`define FMS_REGION_FIELD 13:12
`define FMS_ABOVE_OFFS_FIELD 23:8
`define FMS_ERASED 8'hff

// serial frame layout
`define FMS_LAST_BIT 3'd7
`define FMS_LAST_ADDR_BYTE 3'd3
`define FMS_HDR_ADDR 3'd3
`define FMS_HDR_DUMMY 3'd4
`define FMS_HDR_NONE 3'd0
`define FMS_FIRST_DATA 3'd4
`define FMS_CMD_ONLY 3'd1

// status fields
`define FMS_LOCK_FIELD 5:3
`define FMS_STATUS_ZERO 8'h00

// parameter-space layout
`define FMS_PRM_RSV_HDR 8'h20
`define FMS_PRM_BASIC_PTR 8'h30
`define FMS_PRM_END 8'h7b

`endif

// ===== design/fms_pin_sync.v
// two-flop synchronisers and edge finders for the serial pins
`timescale 1ns/10ps
`default_nettype none

module fms_pin_sync (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire sclk_in,
    input wire sel_n_in,
    input wire serial_in_line_in,
    output wire sclk_rise_out,
    output wire sclk_fall_out,
    output wire sel_n_out,
    output wire sel_rise_out,
    output wire serial_in_line_out
);

    reg [2:0] meta;
    reg [2:0] stable;
    reg sclk_prev;
    reg sel_prev;

    // first stage feeds only the second; deselect resets to high
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta <= 3'h2;
            stable <= 3'h2;
            sclk_prev <= 1'b0;
            sel_prev <= 1'b1;
        end else begin
            meta <= {serial_in_line_in, sel_n_in, sclk_in};
            stable <= meta;
            sclk_prev <= stable[0];
            sel_prev <= stable[1];
        end
    end

    // edges found on the settled copies only
    assign sclk_rise_out = stable[0] & ~sclk_prev;
    assign sclk_fall_out = ~stable[0] & sclk_prev;
    assign sel_n_out = stable[1];
    assign sel_rise_out = stable[1] & ~sel_prev;
    assign serial_in_line_out = stable[2];

endmodule // fms_pin_sync

`default_nettype wire

// ===== design/fms_flash_map.v
// serial nor flash array map with security regions and parameter space
`timescale 1ns/10ps
`default_nettype none
`include "fms_defs.vh"

module fms_flash_map #(
    parameter [7:0] VENDOR_PARAM_ID = 8'ha5 // arbitrary neutral value
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire sclk_in,
    input wire sel_n_in,
    input wire serial_in_line_in,
    output reg serial_out_out,
    output reg serial_oe_n_out,
    output reg busy_out
);

    wire sclk_rise;
    wire sclk_fall;
    wire sel_n;
    wire sel_rise;
    wire si;

    reg [7:0] cmd;
    reg [23:0] addr;
    reg [2:0] bit_cnt;
    reg [2:0] byte_cnt;
    reg [6:0] rx;
    reg [7:0] rd_byte;
    reg [6:0] tx_sh;
    reg out_en;
    reg [2:0] lock;
    reg wr_en;
    reg wr_sec;
    reg [20:0] wr_addr;
    reg [7:0] wr_data;
    reg [21:0] er_left;
    reg [20:0] er_addr;
    reg er_sec;

    reg [7:0] arr [0:`FMS_ARRAY_TOP];
    reg [7:0] sec [0:`FMS_SEC_TOP];
    integer i;

    wire busy = (er_left != 22'h000000);
    wire [7:0] rx_byte = {rx, si};
    wire [23:0] cur_addr = (byte_cnt <= `FMS_LAST_ADDR_BYTE) ? {addr[15:0], rx_byte} : addr;

    fms_pin_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .sclk_in(sclk_in),
        .sel_n_in(sel_n_in),
        .serial_in_line_in(serial_in_line_in),
        .sclk_rise_out(sclk_rise),
        .sclk_fall_out(sclk_fall),
        .sel_n_out(sel_n),
        .sel_rise_out(sel_rise),
        .serial_in_line_out(si)
    );

    // parameter space contents; region 0 is a rom, so no path can alter it
    function [7:0] param_rom;
        input [23:0] a;
        begin
            param_rom = `FMS_ERASED;
            if (a[`FMS_ABOVE_OFFS_FIELD] == 16'h0000) begin
                case (a[`FMS_OFFS_FIELD])
                    8'h00: param_rom = 8'h53;
                    8'h01: param_rom = 8'h46;
                    8'h02: param_rom = 8'h44;
                    8'h03: param_rom = 8'h50;
                    8'h04: param_rom = 8'h08;
                    8'h05: param_rom = 8'h01;
                    8'h06: param_rom = 8'h01;
                    8'h07: param_rom = 8'hff;
                    8'h08: param_rom = 8'h00;
                    8'h09: param_rom = 8'h07;
                    8'h0a: param_rom = 8'h01;
                    8'h0b: param_rom = 8'h10;
                    8'h0c: param_rom = `FMS_PRM_BASIC_PTR;
                    8'h0d: param_rom = 8'h00;
                    8'h0e: param_rom = 8'h00;
                    8'h0f: param_rom = 8'hff;
                    8'h10: param_rom = VENDOR_PARAM_ID;
                    8'h11: param_rom = 8'h00;
                    8'h12: param_rom = 8'h01;
                    8'h13: param_rom = 8'h03;
                    8'h14: param_rom = 8'h70;
                    8'h15: param_rom = 8'h00;
                    8'h16: param_rom = 8'h00;
                    8'h17: param_rom = 8'hff;
                    // basic table first word; the rest reads erased
                    8'h30: param_rom = 8'he5;
                    8'h31: param_rom = 8'h20;
                    8'h32: param_rom = 8'hf1;
                    8'h33: param_rom = 8'hff;
                    default: param_rom = `FMS_ERASED;
                endcase
            end
        end
    endfunction

    // true for commands that stream data back to the host
    function is_read;
        input [7:0] c;
        begin
            is_read = (c == `FMS_CMD_READ) || (c == `FMS_CMD_PARAM_READ) ||
                (c == `FMS_CMD_SEC_READ) || (c == `FMS_CMD_RD_STATUS1) ||
                (c == `FMS_CMD_RD_STATUS2);
        end
    endfunction

    // index of the last byte before read data
    function [2:0] hdr_len;
        input [7:0] c;
        begin
            case (c)
                `FMS_CMD_READ: hdr_len = `FMS_HDR_ADDR;
                `FMS_CMD_PARAM_READ: hdr_len = `FMS_HDR_DUMMY;
                `FMS_CMD_SEC_READ: hdr_len = `FMS_HDR_DUMMY;
                default: hdr_len = `FMS_HDR_NONE;
            endcase
        end
    endfunction

    // array and parameter reads run on; region and page access wrap at 256
    function [23:0] next_addr;
        input [7:0] c;
        input [23:0] a;
        begin
            if (c == `FMS_CMD_READ || c == `FMS_CMD_PARAM_READ)
                next_addr = a + 24'h000001;
            else
                next_addr = {a[`FMS_ABOVE_OFFS_FIELD], a[`FMS_OFFS_FIELD] + 8'h01};
        end
    endfunction

    // storage index of a security region byte
    function [9:0] sec_index;
        input [23:0] a;
        begin
            sec_index = {a[`FMS_REGION_FIELD], a[`FMS_OFFS_FIELD]};
        end
    endfunction

    // region 0 never writable; others until their lock bit is set
    function region_writable;
        input [1:0] r;
        input [2:0] lk;
        begin
            case (r)
                2'd1: region_writable = ~lk[0];
                2'd2: region_writable = ~lk[1];
                2'd3: region_writable = ~lk[2];
                default: region_writable = 1'b0;
            endcase
        end
    endfunction

    // source byte for the current read command
    function [7:0] fetch;
        input [7:0] c;
        input [23:0] a;
        begin
            case (c)
                `FMS_CMD_READ: fetch = arr[a[`FMS_ARRAY_FIELD]];
                `FMS_CMD_PARAM_READ: fetch = param_rom(a);
                `FMS_CMD_SEC_READ: begin
                    if (a[`FMS_REGION_FIELD] == 2'd0)
                        fetch = param_rom({16'h0000, a[`FMS_OFFS_FIELD]});
                    else
                        fetch = sec[sec_index(a)];
                end
                `FMS_CMD_RD_STATUS1: fetch = {7'h00, busy};
                `FMS_CMD_RD_STATUS2: begin
                    fetch = `FMS_STATUS_ZERO;
                    fetch[`FMS_LOCK_FIELD] = lock;
                end
                default: fetch = `FMS_ERASED;
            endcase
        end
    endfunction

    // factory state: everything erased
    initial begin
        for (i = 0; i <= `FMS_ARRAY_TOP; i = i + 1)
            arr[i] = `FMS_ERASED;
        for (i = 0; i <= `FMS_SEC_TOP; i = i + 1)
            sec[i] = `FMS_ERASED;
    end

    // storage writes; busy keeps programs and erases from overlapping
    always @(posedge ref_clk_in) begin
        if (busy) begin
            if (er_sec)
                sec[er_addr[9:0]] <= `FMS_ERASED;
            else
                arr[er_addr] <= `FMS_ERASED;
        end
        if (wr_en) begin
            if (wr_sec)
                sec[wr_addr[9:0]] <= sec[wr_addr[9:0]] & wr_data;
            else
                arr[wr_addr] <= arr[wr_addr] & wr_data;
        end
    end

    // serial command engine, one byte erased per clock while busy
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd <= `FMS_CMD_NONE;
            addr <= 24'h000000;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            rx <= 7'h00;
            rd_byte <= `FMS_ERASED;
            tx_sh <= 7'h7f;
            out_en <= 1'b0;
            serial_out_out <= 1'b1;
            serial_oe_n_out <= 1'b1;
            busy_out <= 1'b0;
            lock <= 3'h0;
            wr_en <= 1'b0;
            wr_sec <= 1'b0;
            wr_addr <= 21'h000000;
            wr_data <= `FMS_ERASED;
            er_left <= 22'h000000;
            er_addr <= 21'h000000;
            er_sec <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            busy_out <= busy;
            if (busy) begin
                er_left <= er_left - 22'h000001;
                er_addr <= er_addr + 21'h000001;
            end
            if (sel_n) begin
                // deselect ends the frame and floats the output
                bit_cnt <= 3'h0;
                byte_cnt <= 3'h0;
                out_en <= 1'b0;
                serial_oe_n_out <= 1'b1;
                cmd <= `FMS_CMD_NONE;
                // erases start only on a whole frame, never mid-transfer
                if (sel_rise && !busy) begin
                    case (cmd)
                        `FMS_CMD_SECT_ERASE: begin
                            if (byte_cnt == `FMS_FIRST_DATA) begin
                                er_addr <= {addr[`FMS_SECTOR_FIELD], 12'h000};
                                er_left <= `FMS_SECTOR_BYTES;
                                er_sec <= 1'b0;
                            end
                        end
                        `FMS_CMD_BLOCK_ERASE: begin
                            if (byte_cnt == `FMS_FIRST_DATA) begin
                                er_addr <= {addr[`FMS_BLOCK_FIELD], 16'h0000};
                                er_left <= `FMS_BLOCK_BYTES;
                                er_sec <= 1'b0;
                            end
                        end
                        `FMS_CMD_CHIP_ERASE: begin
                            if (byte_cnt == `FMS_CMD_ONLY) begin
                                er_addr <= 21'h000000;
                                er_left <= `FMS_CHIP_BYTES;
                                er_sec <= 1'b0;
                            end
                        end
                        `FMS_CMD_SEC_ERASE: begin
                            if (byte_cnt == `FMS_FIRST_DATA &&
                                region_writable(addr[`FMS_REGION_FIELD], lock)) begin
                                er_addr <= {11'h000, addr[`FMS_REGION_FIELD], 8'h00};
                                er_left <= `FMS_REGION_BYTES;
                                er_sec <= 1'b1;
                            end
                        end
                        default: er_sec <= er_sec;
                    endcase
                end
            end else begin
                if (sclk_rise) begin
                    rx <= rx_byte[6:0];
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == `FMS_LAST_BIT) begin
                        if (byte_cnt != 3'h7)
                            byte_cnt <= byte_cnt + 3'h1;
                        if (byte_cnt == 3'h0) begin
                            // only status polling gets through while busy
                            if (busy && rx_byte != `FMS_CMD_RD_STATUS1)
                                cmd <= `FMS_CMD_NONE;
                            else
                                cmd <= rx_byte;
                            if (rx_byte == `FMS_CMD_RD_STATUS1 ||
                                (!busy && rx_byte == `FMS_CMD_RD_STATUS2)) begin
                                rd_byte <= fetch(rx_byte, addr);
                                out_en <= 1'b1;
                            end
                        end else begin
                            addr <= cur_addr;
                            if (is_read(cmd) && byte_cnt >= hdr_len(cmd)) begin
                                rd_byte <= fetch(cmd, cur_addr);
                                addr <= next_addr(cmd, cur_addr);
                                out_en <= 1'b1;
                            end
                            if (cmd == `FMS_CMD_PROG && byte_cnt >= `FMS_FIRST_DATA) begin
                                wr_en <= 1'b1;
                                wr_sec <= 1'b0;
                                wr_addr <= cur_addr[`FMS_ARRAY_FIELD];
                                wr_data <= rx_byte;
                                addr <= next_addr(cmd, cur_addr);
                            end
                            if (cmd == `FMS_CMD_SEC_PROG && byte_cnt >= `FMS_FIRST_DATA) begin
                                wr_en <= region_writable(cur_addr[`FMS_REGION_FIELD], lock);
                                wr_sec <= 1'b1;
                                wr_addr <= {11'h000, sec_index(cur_addr)};
                                wr_data <= rx_byte;
                                addr <= next_addr(cmd, cur_addr);
                            end
                            if (cmd == `FMS_CMD_WR_STATUS2 && byte_cnt == `FMS_CMD_ONLY)
                                lock <= lock | rx_byte[`FMS_LOCK_FIELD];
                        end
                    end
                end
                // data leaves on the falling edge, msb first
                if (sclk_fall && out_en) begin
                    serial_oe_n_out <= 1'b0;
                    if (bit_cnt == 3'h0) begin
                        serial_out_out <= rd_byte[7];
                        tx_sh <= rd_byte[6:0];
                    end else begin
                        serial_out_out <= tx_sh[6];
                        tx_sh <= {tx_sh[5:0], 1'b1};
                    end
                end
            end
        end
    end

endmodule // fms_flash_map

`default_nettype wire

// ===== sim/fms_flash_map_props.sv
// checker for the flash map serial port timing and erase lengths
`timescale 1ns/10ps
`default_nettype none

module fms_flash_map_props (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic sclk_in,
    input wire logic sel_n_in,
    input wire logic serial_in_line_in,
    input wire logic serial_out_out,
    input wire logic serial_oe_n_out,
    input wire logic busy_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    logic sclk_q;
    logic [7:0] since_fall;
    logic [21:0] busy_len;

    // cycles since the raw serial clock fell, and length of the busy level
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_q <= 1'b0;
            since_fall <= 8'hff;
            busy_len <= 22'h0;
        end else begin
            sclk_q <= sclk_in;
            if (sclk_q && !sclk_in) begin
                since_fall <= 8'h0;
            end else if (since_fall != 8'hff) begin
                since_fall <= since_fall + 8'h1;
            end
            busy_len <= busy_out ? busy_len + 22'h1 : 22'h0;
        end
    end

    a_oe_idle_desel: assert property (sel_n_in [*6] |-> serial_oe_n_out)
        else $error("serial output driven while deselected");
    a_oe_in_frame: assert property (!serial_oe_n_out |-> !$past(sel_n_in, 5))
        else $error("serial output driven outside a frame");
    a_oe_release: assert property ($rose(serial_oe_n_out) |-> sel_n_in)
        else $error("serial output released inside a frame");
    a_oe_fall_low: assert property ($fell(serial_oe_n_out) |-> !sel_n_in && !sclk_in)
        else $error("first read bit not launched in clock low phase");
    a_out_sclk_low: assert property ($changed(serial_out_out) && !serial_oe_n_out |-> !sclk_in)
        else $error("read data changed while serial clock high");
    a_out_fall_delay: assert property ($changed(serial_out_out) && !serial_oe_n_out
        |-> since_fall >= 8'h1 && since_fall <= 8'h6)
        else $error("read data not shifted shortly after clock fall");
    a_erase_desel: assert property ($rose(busy_out) |-> sel_n_in)
        else $error("erase started inside a frame");
    a_erase_length: assert property ($fell(busy_out) && busy_len != 22'h0
        |-> busy_len inside {22'd256, 22'd257, 22'd4096, 22'd4097, 22'd65536, 22'd65537,
        22'd2097152, 22'd2097153})
        else $error("erase length is not a region, sector, block or chip");

    c_read_out: cover property ($fell(serial_oe_n_out));
    c_erase_done: cover property ($fell(busy_out));
    c_poll_busy: cover property (busy_out && !sel_n_in);
endmodule // fms_flash_map_props

bind fms_flash_map fms_flash_map_props i_props (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .sel_n_in(sel_n_in),
    .serial_in_line_in(serial_in_line_in),
    .serial_out_out(serial_out_out),
    .serial_oe_n_out(serial_oe_n_out),
    .busy_out(busy_out)
);

`default_nettype wire

// ===== sim/fms_spi_host.sv
// host controller model driving the serial flash port in mode 0
`timescale 1ns/10ps
`default_nettype none

module fms_spi_host (
    input wire logic ref_clk_in,
    input wire logic serial_out_in,
    input wire logic serial_oe_n_in,
    output logic sclk_out,
    output logic sel_n_out,
    output logic mosi_out
);
    logic [7:0] tx_buf [0:7];
    logic [7:0] rx_buf [0:15];
    logic slow = 1'b0;
    wire line;

    // no pull on the line: released, it reads the inverse of the held bit,
    // so a held bit that is not yet driven reads inverted, and a missing drive reads one constant level
    assign line = serial_oe_n_in ? ~serial_out_in : serial_out_in;

    initial begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask

    // 200 ns bit time; clock stands low between frames; slow adds gaps between bytes
    task automatic frame(input int ntx, input int nrx);
        int i;
        int b;
        tick(1);
        sel_n_out = 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            for (b = 7; b >= 0; b--) begin
                mosi_out = (i < ntx) ? tx_buf[i][b] : ~mosi_out;
                tick(6);
                if (i >= ntx) rx_buf[i - ntx][b] = line;
                sclk_out = 1'b1;
                tick(2);
                sclk_out = 1'b0;
            end
            if (slow) tick(16);
        end
        tick(4);
        sel_n_out = 1'b1;
        mosi_out = ~mosi_out;
        tick(8);
    endtask
endmodule // fms_spi_host

`default_nettype wire

// ===== sim/fms_flash_map_bench.sv
// self-checking bench for the flash map and parameter space
`timescale 1ns/10ps
`default_nettype none

module fms_flash_map_bench;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    wire sclk;
    wire sel_n;
    wire mosi;
    wire miso;
    wire miso_oe_n;
    wire busy;
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] hdr [0:15] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h01, 8'hff,
        8'h00, 8'h07, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff};

    always #12.5 ref_clk_in = ~ref_clk_in;

    fms_flash_map i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
        .sel_n_in(sel_n), .serial_in_line_in(mosi), .serial_out_out(miso),
        .serial_oe_n_out(miso_oe_n), .busy_out(busy));
    fms_spi_host i_host (.ref_clk_in(ref_clk_in), .serial_out_in(miso),
        .serial_oe_n_in(miso_oe_n), .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi));

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one frame: command, address bytes, up to two data bytes, then nrx bytes read
    task automatic xfer(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d0,
        input logic [7:0] d1, input int ntx, input int nrx);
        i_host.tx_buf[0] = c;
        i_host.tx_buf[1] = a[23:16];
        i_host.tx_buf[2] = a[15:8];
        i_host.tx_buf[3] = a[7:0];
        i_host.tx_buf[4] = d0;
        i_host.tx_buf[5] = d1;
        i_host.frame(ntx, nrx);
    endtask

    task automatic rd(input logic [7:0] c, input logic [23:0] a, input int n);
        xfer(c, a, 8'h00, 8'h00, (c == 8'h03) ? 4 : 5, n);
    endtask

    task automatic rd1(input logic [7:0] c, input logic [23:0] a, input logic [7:0] exp,
        input string what);
        rd(c, a, 1);
        check8(i_host.rx_buf[0], exp, what);
    endtask

    task automatic pgm(input logic [23:0] a, input logic [7:0] d);
        xfer(8'h02, a, d, 8'hff, 5, 0);
    endtask

    // bounded wait; a hang ends the run as a mismatch
    task automatic wait_idle();
        int i;
        // look just after each edge, never in the time step that updates busy
        for (i = 0; i < 70000 && busy !== 1'b0; i++) begin
            @(posedge ref_clk_in);
            #2;
        end
        if (busy !== 1'b0) begin
            n_errors++;
            $display("[FAIL] %0t erase never finished", $time);
            stop_test();
        end
    endtask

    task automatic t_header();
        int k;
        i_host.slow = 1'b1;
        rd(8'h5a, 24'h000000, 16);
        for (k = 0; k < 16; k++) check8(i_host.rx_buf[k], hdr[k], "header byte");
        i_host.slow = 1'b0;
        $display("test header done");
    endtask

    task automatic t_space();
        rd(8'h5a, 24'h00002f, 2);
        check8(i_host.rx_buf[0], 8'hff, "gap before table");
        check8(i_host.rx_buf[1], 8'he5, "basic table start");
        rd1(8'h5a, 24'h000020, 8'hff, "header reserve");
        rd1(8'h5a, 24'h00007c, 8'hff, "reserved tail");
        rd1(8'h48, 24'h000000, 8'h53, "region 0 data");
        $display("test parameter space done");
    endtask

    task automatic t_program();
        pgm(24'h000000, 8'h00);
        rd1(8'h5a, 24'h000000, 8'h53, "separate space");
        rd1(8'h03, 24'h000000, 8'h00, "array byte 0");
        pgm(24'h012345, 8'h0f);
        pgm(24'h012345, 8'hf3);
        rd1(8'h03, 24'h012345, 8'h03, "ones to zero only");
        xfer(8'h02, 24'h0120ff, 8'h11, 8'h22, 6, 0);
        rd1(8'h03, 24'h012000, 8'h22, "page wrap");
        rd1(8'h03, 24'h012100, 8'hff, "next page intact");
        $display("test program done");
    endtask

    task automatic t_erase();
        pgm(24'h011fff, 8'h00);
        pgm(24'h013000, 8'h00);
        pgm(24'h020000, 8'h00);
        xfer(8'h20, 24'h012abc, 8'h00, 8'h00, 4, 0);
        xfer(8'h05, 24'h000000, 8'h00, 8'h00, 1, 1);
        check8(i_host.rx_buf[0], 8'h01, "busy during erase");
        wait_idle();
        rd1(8'h03, 24'h012345, 8'hff, "sector erased");
        rd1(8'h03, 24'h011fff, 8'h00, "sector below kept");
        rd1(8'h03, 24'h013000, 8'h00, "sector above kept");
        xfer(8'hd8, 24'h01ffff, 8'h00, 8'h00, 4, 0);
        wait_idle();
        rd1(8'h03, 24'h013000, 8'hff, "block erased");
        rd1(8'h03, 24'h020000, 8'h00, "next block kept");
        // chip erase only on a one-byte frame; a longer one must not start it
        xfer(8'hc7, 24'h000000, 8'h00, 8'h00, 2, 0);
        xfer(8'h05, 24'h000000, 8'h00, 8'h00, 1, 1);
        check8(i_host.rx_buf[0], 8'h00, "long chip erase frame ignored");
        $display("test erase done");
    endtask

    task automatic t_regions();
        xfer(8'h42, 24'h001010, 8'h5a, 8'h00, 5, 0);
        xfer(8'h42, 24'h0030ff, 8'h77, 8'h00, 5, 0);
        xfer(8'h42, 24'h000004, 8'h00, 8'h00, 5, 0);
        rd1(8'h48, 24'h001010, 8'h5a, "region 1 byte");
        rd1(8'h48, 24'h0030ff, 8'h77, "region 3 top");
        rd1(8'h48, 24'h000004, 8'h08, "region 0 read only");
        xfer(8'h31, 24'h080000, 8'h00, 8'h00, 2, 0);
        xfer(8'h31, 24'h000000, 8'h00, 8'h00, 2, 0);
        xfer(8'h35, 24'h000000, 8'h00, 8'h00, 1, 1);
        check8(i_host.rx_buf[0] & 8'h38, 8'h08, "lock bit sticks");
        xfer(8'h42, 24'h001011, 8'h00, 8'h00, 5, 0);
        rd1(8'h48, 24'h001011, 8'hff, "locked program refused");
        xfer(8'h44, 24'h001000, 8'h00, 8'h00, 4, 0);
        wait_idle();
        rd1(8'h48, 24'h001010, 8'h5a, "locked erase refused");
        xfer(8'h44, 24'h003000, 8'h00, 8'h00, 4, 0);
        wait_idle();
        rd1(8'h48, 24'h0030ff, 8'hff, "region 3 erased");
        $display("test regions done");
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_in);
        #2;
        check8({5'h00, miso, miso_oe_n, busy}, 8'h06, "reset levels");
        reset_n_in = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        t_header();
        t_space();
        t_program();
        t_erase();
        t_regions();
        stop_test();
    end
endmodule // fms_flash_map_bench

`default_nettype wire
